// >>> src/mpg_channel.sv
// one pwm channel: high/low counter with period-boundary reload
`timescale 1ns/1ps
`include "mpg_defines.svh"
module mpg_channel
   import mpg_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   input wire logic mclk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic tick, // input clock enable from the divider chain
   mpg_ch_if.chan ch // settings and status
);
   mpg_state_e state_reg;
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] high_act_reg;
   logic [DIV_W-1:0] low_act_reg;
   logic pend_reg;
   logic [DIV_W-1:0] high_pend_reg;
   logic [DIV_W-1:0] low_pend_reg;
   logic wave_reg;
   logic period_end;

   // ************
   // pending settings
   // ************
   assign period_end = tick && state_reg == MPG_LOW && cnt_reg <= DIV_W'(1);

   // a load landing on the period end wins over its consumption
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_reg <= 1'b0;
         high_pend_reg <= `MPG_DIV_RESET;
         low_pend_reg <= `MPG_DIV_RESET;
      end
      else if (ch.load)
      begin
         pend_reg <= 1'b1;
         high_pend_reg <= ch.high_div;
         low_pend_reg <= ch.low_div;
      end
      else if (period_end || state_reg == MPG_IDLE)
         pend_reg <= 1'b0;
   end

   // ************
   // high/low sequencer
   // ************
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= MPG_IDLE;
         cnt_reg <= '0;
         high_act_reg <= `MPG_DIV_RESET;
         low_act_reg <= `MPG_DIV_RESET;
         wave_reg <= 1'b0;
      end
      else if (!ch.enable)
      begin
         state_reg <= MPG_IDLE;
         wave_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            MPG_IDLE:
            begin
               if (pend_reg)
               begin
                  high_act_reg <= high_pend_reg;
                  low_act_reg <= low_pend_reg;
                  cnt_reg <= high_pend_reg;
                  state_reg <= MPG_HIGH;
                  wave_reg <= 1'b1;
               end
            end
            MPG_HIGH:
            begin
               if (tick)
               begin
                  if (cnt_reg <= DIV_W'(1))
                  begin
                     cnt_reg <= low_act_reg;
                     state_reg <= MPG_LOW;
                     wave_reg <= 1'b0;
                  end
                  else
                     cnt_reg <= cnt_reg - 1'b1;
               end
            end
            MPG_LOW:
            begin
               if (tick)
               begin
                  if (cnt_reg > DIV_W'(1))
                     cnt_reg <= cnt_reg - 1'b1;
                  else if (ch.oneshot)
                     state_reg <= MPG_IDLE;
                  else
                  begin
                     // new values only at the period boundary
                     if (pend_reg)
                     begin
                        high_act_reg <= high_pend_reg;
                        low_act_reg <= low_pend_reg;
                        cnt_reg <= high_pend_reg;
                     end
                     else
                        cnt_reg <= high_act_reg;
                     state_reg <= MPG_HIGH;
                     wave_reg <= 1'b1;
                  end
               end
            end
            default: state_reg <= MPG_IDLE;
         endcase
      end
   end

   assign ch.wave = wave_reg;
   assign ch.busy = state_reg != MPG_IDLE;
endmodule

// >>> src/mpg_defines.svh
// constants for the multi-channel pwm generator
`ifndef MPG_DEFINES_SVH
`define MPG_DEFINES_SVH
`define MPG_NUM_CH 6
`define MPG_DIV_W 16
`define MPG_DIV_RESET 16'h0001
`endif

// >>> src/mpg_pkg.sv
// types for the multi-channel pwm generator
package mpg_pkg;
   typedef enum logic [1:0] {MPG_IDLE, MPG_HIGH, MPG_LOW} mpg_state_e;
endpackage

// >>> src/mpg_ch_if.sv
// interface carrying settings and status between the top and one channel
`timescale 1ns/1ps
interface mpg_ch_if #(parameter int DIV_W = 16);
   logic enable;
   logic oneshot;
   logic load;
   logic [DIV_W-1:0] high_div;
   logic [DIV_W-1:0] low_div;
   logic wave;
   logic busy;
   modport top (output enable, oneshot, load, high_div, low_div, input wave, busy);
   modport chan (input enable, oneshot, load, high_div, low_div, output wave, busy);
endinterface

// >>> src/mpg_top.sv
// six-channel pwm generator top: clock select, update control, pair inversion
`timescale 1ns/1ps
`include "mpg_defines.svh"
module mpg_top
   import mpg_pkg::*;
#(
   parameter int NUM_CH = `MPG_NUM_CH,
   parameter int DIV_W = `MPG_DIV_W
)
(
   input wire logic mclk, // system clock, 200 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic pll_tick, // one-cycle enable at the pll channel rate
   input wire logic xtal_tick, // one-cycle enable at the crystal rate
   input wire logic [NUM_CH-1:0] clk_sel, // per channel: 1 pll, 0 crystal
   input wire logic [NUM_CH-1:0] ch_enable, // per channel run enable
   input wire logic [NUM_CH-1:0] ch_oneshot, // per channel single-pulse mode
   input wire logic [NUM_CH-1:0] ch_group, // per channel: waits for group strobe
   input wire logic [NUM_CH-1:0] ch_write, // per channel settings write strobe
   input wire logic [NUM_CH*DIV_W-1:0] high_div, // high periods, per channel
   input wire logic [NUM_CH*DIV_W-1:0] low_div, // low periods, per channel
   input wire logic group_update, // commit strobe for grouped channels
   input wire logic [NUM_CH/2-1:0] pair_invert, // invert odd output of each pair
   output logic [NUM_CH-1:0] pwm_out, // pwm outputs
   output logic [NUM_CH-1:0] ch_busy // channel running
);
   // odd counts would leave a channel with no pair partner
   if (NUM_CH < 2 || NUM_CH > `MPG_NUM_CH || NUM_CH % 2 != 0 || DIV_W < 2)
   begin : g_bad_param
      $error("mpg_top: unsupported NUM_CH or DIV_W");
   end

   logic [NUM_CH-1:0] stage_reg;
   logic [NUM_CH*DIV_W-1:0] high_stage_reg;
   logic [NUM_CH*DIV_W-1:0] low_stage_reg;
   logic [NUM_CH-1:0] wave;

   // ************
   // per-channel staging and instances
   // ************
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++)
      begin : g_ch
         mpg_ch_if #(.DIV_W(DIV_W)) chi ();
         logic tick;

         assign tick = clk_sel[i] ? pll_tick : xtal_tick;

         // grouped writes are held until the shared commit
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               stage_reg[i] <= 1'b0;
               high_stage_reg[i*DIV_W +: DIV_W] <= `MPG_DIV_RESET;
               low_stage_reg[i*DIV_W +: DIV_W] <= `MPG_DIV_RESET;
            end
            else if (ch_write[i])
            begin
               stage_reg[i] <= 1'b1;
               high_stage_reg[i*DIV_W +: DIV_W] <= high_div[i*DIV_W +: DIV_W];
               low_stage_reg[i*DIV_W +: DIV_W] <= low_div[i*DIV_W +: DIV_W];
            end
            else if (!ch_group[i] || group_update)
               stage_reg[i] <= 1'b0;
         end

         assign chi.enable = ch_enable[i];
         assign chi.oneshot = ch_oneshot[i];
         assign chi.load = stage_reg[i] && (!ch_group[i] || group_update);
         assign chi.high_div = high_stage_reg[i*DIV_W +: DIV_W];
         assign chi.low_div = low_stage_reg[i*DIV_W +: DIV_W];
         assign wave[i] = chi.wave;

         mpg_channel #(.DIV_W(DIV_W)) u_ch (
            .mclk(mclk),
            .rst_b(rst_b),
            .tick(tick),
            .ch(chi)
         );

         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               ch_busy[i] <= 1'b0;
            else
               ch_busy[i] <= chi.busy;
         end
      end
   endgenerate

   // ************
   // output stage
   // ************
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         pwm_out <= '0;
      else
      begin
         for (int p = 0; p < NUM_CH; p++)
         begin
            if (p % 2 == 1 && pair_invert[p/2])
               pwm_out[p] <= ~wave[p];
            else
               pwm_out[p] <= wave[p];
         end
      end
   end
endmodule

// >>> testbench/mpg_top_sva.sv
// checker on the pwm generator top ports
`timescale 1ns/1ps
module mpg_top_sva
#(
   parameter int NUM_CH = 6
)
(
   input wire logic mclk, // clock
   input wire logic rst_b, // reset
   input wire logic [NUM_CH-1:0] ch_enable, // enables
   input wire logic [NUM_CH-1:0] ch_oneshot, // modes
   input wire logic [NUM_CH-1:0] ch_group, // grouping
   input wire logic [NUM_CH-1:0] ch_write, // writes
   input wire logic group_update, // commit
   input wire logic [NUM_CH/2-1:0] pair_invert, // inversion
   input wire logic [NUM_CH-1:0] pwm_out, // outputs
   input wire logic [NUM_CH-1:0] ch_busy // running
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   start_write_a:
      assert property ((ch_write[0] && !ch_group[0] && !ch_busy[0] ##0 ch_enable[0] [*4])
         |=> ch_busy[0]) else $error("no start");
   group_hold_a:
      assert property ((ch_group[0] && !ch_busy[0] && !group_update) [*4] |=> !ch_busy[0])
         else $error("group early");
   ch_isolate_a:
      assert property ((!ch_busy[1] && !ch_write[1] && !group_update && $stable(ch_group[1]))
         [*4] |=> !ch_busy[1]) else $error("stray start");
   abort_idle_a:
      assert property (!ch_enable[0] [*2] |=> !ch_busy[0] && !pwm_out[0])
         else $error("no abort");
   pair_idle_a:
      assert property ((!ch_enable[1] && !pair_invert[0]) [*2] |=> !pwm_out[1])
         else $error("odd idle");
   run_hold_a:
      assert property (ch_busy[0] && ch_enable[0] && $past(ch_enable[0]) && !ch_oneshot[0]
         && !$past(ch_oneshot[0]) |=> ch_busy[0]) else $error("run stopped");
   shot_stop_a:
      assert property (((ch_enable[2] && !ch_write[2] && !ch_group[2]) [*4]
         ##1 ($fell(ch_busy[2]) && ch_oneshot[2] && !ch_write[2] && !ch_group[2])
         ##1 (!ch_write[2] && !ch_group[2]) [*3]) |=> !ch_busy[2])
         else $error("shot restart");
   out_busy_a:
      assert property (pwm_out[0] |-> ch_busy[0]) else $error("out idle");
   cover property ($rose(ch_busy[2]) && ch_oneshot[2]);
   cover property ($rose(ch_busy[0]) && $rose(ch_busy[1]));
   cover property (pair_invert[0] && ch_busy[1]);
endmodule
bind mpg_top mpg_top_sva #(.NUM_CH(NUM_CH)) i_sva (.mclk(mclk), .rst_b(rst_b),
   .ch_enable(ch_enable), .ch_oneshot(ch_oneshot), .ch_group(ch_group),
   .ch_write(ch_write), .group_update(group_update), .pair_invert(pair_invert),
   .pwm_out(pwm_out), .ch_busy(ch_busy));

// >>> testbench/mpg_load.sv
// load model: measures the last high and low run of one output
`timescale 1ns/1ps
module mpg_load
(
   input wire logic mclk, // clock
   input wire logic pwm, // driven line
   output int hi_len, // last high run
   output int lo_len // last low run
);
   int run = 0;
   logic last = 1'b0;
   always @(posedge mclk)
   begin
      if (pwm !== last)
      begin
         if (last)
            hi_len <= run;
         else
            lo_len <= run;
         run <= 1;
      end
      else
         run <= run + 1;
      last <= pwm;
   end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic sel; logic [15:0] hi; logic [15:0] lo; int eh; int el;} mpg_row_s;
   mpg_row_s rows [4] = '{'{1, 16'h0003, 16'h0005, 3, 5}, '{1, 16'h0001, 16'h0002, 1, 2},
      '{0, 16'h0002, 16'h0003, 8, 12}, '{1, 16'h0000, 16'h0004, 1, 4}};
   logic mclk, rst_b, pll_tick, group_update;
   logic xtal_tick = 1'b0;
   logic [5:0] clk_sel, ch_enable, ch_oneshot, ch_group, ch_write, pwm_out, ch_busy;
   logic [95:0] high_div, low_div;
   logic [2:0] pair_invert;
   int h0, l0, h2, xc = 0, err_count = 0, n_tests = 0;
   mpg_top i_dut (.mclk(mclk), .rst_b(rst_b), .pll_tick(pll_tick), .xtal_tick(xtal_tick),
      .clk_sel(clk_sel), .ch_enable(ch_enable), .ch_oneshot(ch_oneshot), .ch_group(ch_group),
      .ch_write(ch_write), .high_div(high_div), .low_div(low_div),
      .group_update(group_update), .pair_invert(pair_invert), .pwm_out(pwm_out),
      .ch_busy(ch_busy));
   mpg_load i_ld0 (.mclk(mclk), .pwm(pwm_out[0]), .hi_len(h0), .lo_len(l0));
   mpg_load i_ld2 (.mclk(mclk), .pwm(pwm_out[2]), .hi_len(h2), .lo_len());
   // crystal-rate enable, one cycle in four
   always @(negedge mclk)
   begin
      xc <= (xc + 1) % 4;
      xtal_tick <= (xc == 3);
   end
   task w(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task wr(input logic [5:0] m, input logic [15:0] h, input logic [15:0] l);
      for (int i = 0; i < 6; i++)
      begin
         if (m[i])
         begin
            high_div[16*i+:16] = h;
            low_div[16*i+:16] = l;
         end
      end
      ch_write = m;
      w(1);
      ch_write = 6'h00;
   endtask
   task stop_test;
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial
   begin
      #20000;
      err_count++;
      stop_test;
   end
   initial
   begin
      {rst_b, group_update, clk_sel, ch_enable, ch_oneshot, ch_group, ch_write} = '0;
      {high_div, low_div, pair_invert} = '0;
      pll_tick = 1'b1;
      w(5);
      chk(pwm_out === 6'h00 && ch_busy === 6'h00, "reset state");
      rst_b = 1'b1;
      foreach (rows[r])
      begin
         clk_sel[0] = rows[r].sel;
         ch_enable[0] = 1'b1;
         wr(6'h01, rows[r].hi, rows[r].lo);
         w(70);
         chk(h0 == rows[r].eh && l0 == rows[r].el, "widths");
         ch_enable[0] = 1'b0;
         w(3);
         chk(ch_busy[0] === 1'b0 && pwm_out[0] === 1'b0, "abort");
      end
      // rewrite in mid-high: old period must finish untouched
      ch_enable[0] = 1'b1;
      wr(6'h01, 16'h0006, 16'h0006);
      w(5);
      wr(6'h01, 16'h0002, 16'h0002);
      w(10);
      chk(h0 == 6, "old high");
      w(40);
      chk(h0 == 2 && l0 == 2, "new period");
      ch_enable[0] = 1'b0;
      ch_group[1:0] = 2'b11;
      clk_sel[1:0] = 2'b11;
      pair_invert[0] = 1'b1;
      w(3);
      ch_enable[1:0] = 2'b11;
      wr(6'h03, 16'h0003, 16'h0002);
      w(5);
      chk(ch_busy[1:0] === 2'b00, "group held");
      group_update = 1'b1;
      w(1);
      group_update = 1'b0;
      w(6);
      chk(ch_busy[1:0] === 2'b11, "group start");
      repeat (8)
      begin
         chk(pwm_out[1] === ~pwm_out[0], "inversion");
         w(1);
      end
      // idle channels 3 to 5 are enabled, so a stray start would show on their busy bits; channels 0 and 1 are disabled
      ch_enable = 6'h3c;
      {ch_oneshot[2], clk_sel[2]} = 2'b11;
      wr(6'h04, 16'h0002, 16'h0003);
      w(20);
      chk(h2 == 2 && ch_busy[2] === 1'b0 && pwm_out[2] === 1'b0, "one pulse");
      chk(ch_busy[5:3] === 3'h0 && ch_busy[1:0] === 2'b00, "isolated");
      stop_test;
   end
endmodule
